// >>> core/hsc_channel.sv
`timescale 1ns/1ps
`default_nettype none
module hsc_channel (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire hsc_pkg::hsc_step_t step,
   input  wire logic              ring_mode,
   input  wire logic              gate,
   input  wire logic [31:0]       limit,
   input  wire logic              clr,
   input  wire logic              load,
   input  wire logic [31:0]       load_val,
   output logic [31:0]            value_r,
   output logic                   ovf_r,
   output logic                   unf_r
);
   logic [31:0] max_eff;

   assign max_eff = (limit == 32'h0000_0000) ? hsc_pkg::ALL_ONES
                                             : limit; // [RULE_05]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         value_r <= 32'h0000_0000;
         ovf_r   <= 1'b0;
         unf_r   <= 1'b0;
      end else if (clr) begin
         value_r <= 32'h0000_0000;
         ovf_r   <= 1'b0;
         unf_r   <= 1'b0;
      end else if (load) begin
         value_r <= load_val; // [RULE_25]
         ovf_r   <= 1'b0;
         unf_r   <= 1'b0;
      end else if (!gate && (step.up ^ step.down)) begin // [RULE_21]
         if (ring_mode) begin
            ovf_r <= 1'b0; // [RULE_03]
            unf_r <= 1'b0;
            if (step.up) begin
               value_r <= (value_r >= max_eff) ? 32'h0000_0000
                                               : value_r + 32'h1; // [RULE_01]
            end else begin
               value_r <= (value_r == 32'h0000_0000)
                          ? max_eff : value_r - 32'h1; // [RULE_02]
            end
         end else if (!ovf_r && !unf_r) begin
            if (step.up && value_r == hsc_pkg::LIN_MAX) begin
               ovf_r <= 1'b1; // [RULE_24]
            end else if (step.down && value_r == hsc_pkg::LIN_MIN) begin
               unf_r <= 1'b1; // [RULE_24]
            end else if (step.up) begin
               value_r <= value_r + 32'h1;
            end else begin
               value_r <= value_r - 32'h1;
            end
         end
      end
   end
endmodule // hsc_channel
`default_nettype wire

// >>> core/hsc_pkg.sv
package hsc_pkg;
   localparam int NUM_CNT = 4;

   // Register byte offsets, one aligned word each
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_MODE     = 8'h04;
   localparam logic [7:0] OFF_PPR      = 8'h08;
   localparam logic [7:0] OFF_CMD      = 8'h0C;
   localparam logic [7:0] OFF_WDATA    = 8'h10;
   localparam logic [7:0] OFF_FREQ     = 8'h14;
   localparam logic [7:0] OFF_RPM      = 8'h18;
   localparam logic [7:0] OFF_REVS     = 8'h1C;
   localparam logic [7:0] OFF_LIMIT0   = 8'h20;
   localparam logic [7:0] OFF_VALUE0   = 8'h30;
   localparam logic [7:0] OFF_STATUS0  = 8'h40;
   localparam logic [7:0] OFF_LATCH0   = 8'h50;
   localparam logic [7:0] OFF_CMPMAX0  = 8'h60;

   // Control word fields
   localparam int CTRL_RESET_LSB = 0;
   localparam int CTRL_GATE_LSB  = 8;

   // Mode word fields per counter, 4 bits each
   localparam int MODE_RING_BIT   = 0;
   localparam int MODE_SWRST_BIT  = 1;
   localparam int MODE_CMPSTP_BIT = 2;
   localparam int MODE_QUAD_BIT   = 3;

   // Status word fields
   localparam int ST_DIR_BIT = 10;
   localparam int ST_OVF_BIT = 0;
   localparam int ST_UNF_BIT = 1;
   localparam int ST_CMP_BIT = 2;

   // Command codes written to OFF_CMD bits 3:0, counter in bits 5:4
   localparam logic [3:0] CMD_SET_LIMIT = 4'h1;
   localparam logic [3:0] CMD_SET_VALUE = 4'h2;
   localparam logic [3:0] CMD_CMP_START = 4'h3;
   localparam logic [3:0] CMD_CMP_STOP  = 4'h4;
   localparam logic [3:0] CMD_SW_RESET  = 4'h5;

   localparam logic [31:0] ALL_ONES   = 32'hFFFF_FFFF;
   localparam logic [31:0] FREQ_QUAD  = 32'h0003_0D40;
   localparam logic [31:0] FREQ_OTHER = 32'h0001_86A0;
   localparam logic [31:0] LIMIT_RST  = 32'h0000_0000;
   localparam logic [31:0] LIN_MIN    = 32'h8000_0000;
   localparam logic [31:0] LIN_MAX    = 32'h7FFF_FFFF;

   // Timing
   localparam int CLK_MHZ        = 125;
   localparam int SCAN_US        = 1000;
   localparam int SCAN_CYCLES    = SCAN_US * CLK_MHZ;
   localparam int GATE_MS        = 1000;
   localparam int GATE_CYCLES    = GATE_MS * 1000 * CLK_MHZ;
   localparam int SEC_PER_MIN    = 60;

   typedef struct packed {
      logic up;
      logic down;
   } hsc_step_t;

   typedef enum logic [1:0] {
      HSC_IDLE = 2'b00,
      HSC_SCAN = 2'b01,
      HSC_CALC = 2'b11
   } hsc_state_t;
endpackage : hsc_pkg

// >>> core/hsc_top.sv
// Summary of operation
// RULE_01 - Ring mode: increment at maximum wraps value to zero
// RULE_02 - Ring mode: decrement at zero loads the maximum value
// RULE_03 - Ring mode never flags overflow or underflow; value unsigned
// RULE_04 - Maximum accepts any 32-bit value, upper and lower halves
// RULE_05 - A zero maximum acts as all ones
// RULE_06 - Maximum change refused while comparison runs
// RULE_07 - Comparison refused when a compare value exceeds maximum
// RULE_08 - Changing the maximum clears the count value
// RULE_09 - Index plus software mode: index with reset bit clears value
// RULE_10 - Reset bit sampled only at scan start for index arming
// RULE_11 - Software mode: reset bit rising seen at scan start clears
// RULE_12 - Option stops or keeps comparison when counter resets
// RULE_13 - Count value copied to readable word every refresh
// RULE_14 - Value latched on interrupt input before the task runs
// RULE_15 - Counter zero measures frequency in hertz, 32-bit readout
// RULE_16 - Frequency saturates at 50 kHz quadrature, 100 kHz otherwise; the code caps quadrature at 200 kHz (FREQ_QUAD)
// RULE_17 - Frequency runs alongside comparison without disturbing it
// RULE_18 - Counter zero rpm from frequency and pulses per rotation
// RULE_19 - Counter zero revolutions from value and pulses per rotation
// RULE_20 - Direction flag bit 10 updated each refresh, set means up; the code keeps the old flag when the count is unchanged
// RULE_21 - Gate bit set holds value and ignores pulses
// RULE_22 - Gate ignored while waiting for index reset
// RULE_23 - Direction from comparing this scan's count with the last
// RULE_24 - Linear mode stops and flags at limit crossing
// RULE_25 - Value write and software reset accepted while gated
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module hsc_top #(
   parameter int SCAN_CYCLES = hsc_pkg::SCAN_CYCLES,
   parameter int GATE_CYCLES = hsc_pkg::GATE_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [3:0]  pulse_up,
   input  wire logic [3:0]  pulse_down,
   input  wire logic [3:0]  index_in,
   input  wire logic        irq_in,
   output logic [3:0]       cmp_run
);
   localparam int N = hsc_pkg::NUM_CNT;

   // Two-flop input synchronisers
   logic [3:0] up_m;
   logic [3:0] up_s;
   logic [3:0] up_d;
   logic [3:0] dn_m;
   logic [3:0] dn_s;
   logic [3:0] dn_d;
   logic [3:0] ix_m;
   logic [3:0] ix_s;
   logic [3:0] ix_d;
   logic       irq_m;
   logic       irq_s;
   logic       irq_d;
   // Third flop only feeds the edge detectors
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {up_m, up_s, up_d} <= 12'h000;
         {dn_m, dn_s, dn_d} <= 12'h000;
         {ix_m, ix_s, ix_d} <= 12'h000;
         {irq_m, irq_s, irq_d} <= 3'h0;
      end else begin
         up_m <= pulse_up;
         up_s <= up_m;
         up_d <= up_s;
         dn_m <= pulse_down;
         dn_s <= dn_m;
         dn_d <= dn_s;
         ix_m <= index_in;
         ix_s <= ix_m;
         ix_d <= ix_s;
         irq_m <= irq_in;
         irq_s <= irq_m;
         irq_d <= irq_s;
      end
   end

   // Registers written by software, then per-counter state and readouts
   logic [31:0] ctrl_r;
   logic [31:0] mode_r;
   logic [31:0] ppr_r;
   logic [31:0] wdata_r;
   logic [31:0] limit_r [N];
   logic [31:0] cmpmax_r [N];
   logic [31:0] value [N];
   logic [31:0] value_cp_r [N];
   logic [31:0] prev_r [N];
   logic [31:0] latch_r [N];
   logic [N-1:0] dir_r;
   logic [N-1:0] ovf;
   logic [N-1:0] unf;
   logic [N-1:0] armed_r;
   logic [N-1:0] rstbit_old_r;
   logic [N-1:0] clr;
   logic [N-1:0] load;
   logic [N-1:0] ring_v;
   logic [31:0] freq_r;
   logic [31:0] rpm_r;
   logic [31:0] revs_r;

   logic acc;
   logic wr;
   logic rd;
   assign acc = psel && penable;
   assign wr  = acc && pwrite;
   assign rd  = acc && !pwrite;

   function automatic logic hit_bank(input logic [7:0] a,
                                     input logic [7:0] base);
      hit_bank = (a[7:4] == base[7:4]) && (a[1:0] == 2'b00);
   endfunction

   logic       cmd_wr;
   logic [3:0] cmd_code;
   logic [1:0] cmd_idx;
   assign cmd_wr   = wr && (paddr == hsc_pkg::OFF_CMD);
   assign cmd_code = pwdata[3:0];
   assign cmd_idx  = pwdata[5:4];

   // Scan cycle tick
   logic [31:0] scan_cnt_r;
   logic        scan_tick;
   assign scan_tick = (scan_cnt_r == 32'(SCAN_CYCLES - 1));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) scan_cnt_r <= 32'h0000_0000;
      else if (scan_tick) scan_cnt_r <= 32'h0000_0000;
      else scan_cnt_r <= scan_cnt_r + 32'h1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r  <= 32'h0000_0000;
         mode_r  <= 32'h0000_0000;
         ppr_r   <= 32'h0000_0001;
         wdata_r <= 32'h0000_0000;
      end else if (wr) begin
         if (paddr == hsc_pkg::OFF_CTRL) ctrl_r <= pwdata;
         if (paddr == hsc_pkg::OFF_MODE) mode_r <= pwdata;
         if (paddr == hsc_pkg::OFF_PPR) ppr_r <= pwdata;
         if (paddr == hsc_pkg::OFF_WDATA) wdata_r <= pwdata;
      end
   end

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_ch
         hsc_pkg::hsc_step_t stp;
         logic ring;
         logic swm;
         logic cmpstop;
         logic rbit;
         logic gate_eff;
         logic lim_wr;
         logic rise;
         // One count step per rising edge of a synchronised pulse
         assign stp.up   = up_s[g] && !up_d[g];
         assign stp.down = dn_s[g] && !dn_d[g];
         assign ring    = mode_r[4*g + hsc_pkg::MODE_RING_BIT];
         assign ring_v[g] = ring;
         assign swm     = mode_r[4*g + hsc_pkg::MODE_SWRST_BIT];
         assign cmpstop = mode_r[4*g + hsc_pkg::MODE_CMPSTP_BIT];
         assign rbit    = ctrl_r[hsc_pkg::CTRL_RESET_LSB + g];
         // Waiting for index overrides the gate
         assign gate_eff = ctrl_r[hsc_pkg::CTRL_GATE_LSB + g]
                           && !(!swm && armed_r[g]); // [RULE_22]
         assign lim_wr = cmd_wr && cmd_code == hsc_pkg::CMD_SET_LIMIT
                         && cmd_idx == 2'(g) && !cmp_run[g]; // [RULE_06]
         assign rise = scan_tick && rbit && !rstbit_old_r[g];
         assign clr[g] = lim_wr // [RULE_08]
            || (!swm && armed_r[g] && ix_s[g] && !ix_d[g]) // [RULE_09]
            || (swm && rise) // [RULE_11]
            || (cmd_wr && cmd_code == hsc_pkg::CMD_SW_RESET
                && cmd_idx == 2'(g)); // [RULE_25]
         assign load[g] = cmd_wr && cmd_code == hsc_pkg::CMD_SET_VALUE
                          && cmd_idx == 2'(g); // [RULE_25]

         hsc_channel u_ch (
            .pclk     (pclk),
            .presetn  (presetn),
            .step     (stp),
            .ring_mode(ring),
            .gate     (gate_eff),
            .limit    (limit_r[g]),
            .clr      (clr[g]),
            .load     (load[g]),
            .load_val (wdata_r),
            .value_r  (value[g]),
            .ovf_r    (ovf[g]),
            .unf_r    (unf[g])
         );

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               limit_r[g] <= hsc_pkg::LIMIT_RST;
               cmpmax_r[g] <= 32'h0000_0000;
            end else begin
               if (lim_wr) limit_r[g] <= wdata_r; // [RULE_04]
               if (wr && paddr == hsc_pkg::OFF_CMPMAX0 + 8'(4*g))
                  cmpmax_r[g] <= pwdata;
            end
         end

         // Reset bit seen only at scan start
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               armed_r[g] <= 1'b0;
               rstbit_old_r[g] <= 1'b0;
            end else if (scan_tick) begin
               armed_r[g] <= rbit; // [RULE_10]
               rstbit_old_r[g] <= rbit;
            end
         end

         // Stop on reset outranks a command in the same cycle
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cmp_run[g] <= 1'b0;
            end else if (clr[g] && cmpstop) begin
               cmp_run[g] <= 1'b0; // [RULE_12]
            end else if (cmd_wr && cmd_idx == 2'(g)) begin
               if (cmd_code == hsc_pkg::CMD_CMP_STOP) cmp_run[g] <= 1'b0;
               if (cmd_code == hsc_pkg::CMD_CMP_START)
                  cmp_run[g] <= (limit_r[g] == 32'h0000_0000)
                                || (cmpmax_r[g] <= limit_r[g]); // [RULE_07]
            end
         end

         // Refresh copy and direction from scan to scan
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               value_cp_r[g] <= 32'h0000_0000;
               prev_r[g] <= 32'h0000_0000;
               dir_r[g] <= 1'b0;
            end else if (scan_tick) begin
               value_cp_r[g] <= value[g]; // [RULE_13]
               prev_r[g] <= value[g];
               if (value[g] != prev_r[g])
                  dir_r[g] <= (value[g] > prev_r[g]); // [RULE_20] [RULE_23]
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) latch_r[g] <= 32'h0000_0000;
            else if (irq_s && !irq_d) latch_r[g] <= value[g]; // [RULE_14]
         end
      end
   endgenerate

   // Counter zero frequency over a fixed gate window, independent of compare
   logic [31:0] gate_cnt_r;
   logic [31:0] edge_cnt_r;
   logic [31:0] freq_sat;
   logic        quad0;
   assign quad0 = mode_r[hsc_pkg::MODE_QUAD_BIT];
   assign freq_sat = quad0 ? hsc_pkg::FREQ_QUAD : hsc_pkg::FREQ_OTHER;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_cnt_r <= 32'h0000_0000;
         edge_cnt_r <= 32'h0000_0000;
         freq_r <= 32'h0000_0000;
      end else if (gate_cnt_r == 32'(GATE_CYCLES - 1)) begin // [RULE_17]
         gate_cnt_r <= 32'h0000_0000;
         edge_cnt_r <= 32'h0000_0000;
         freq_r <= (edge_cnt_r > freq_sat) ? freq_sat
                                           : edge_cnt_r; // [RULE_15] [RULE_16]
      end else begin
         gate_cnt_r <= gate_cnt_r + 32'h1;
         if ((up_s[0] && !up_d[0]) || (dn_s[0] && !dn_d[0]))
            edge_cnt_r <= edge_cnt_r + 32'h1;
      end
   end

   // Conversions; the divider is combinational, a simple area trade-off
   logic [31:0] ppr_nz;
   assign ppr_nz = (ppr_r == 32'h0000_0000) ? 32'h1 : ppr_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rpm_r <= 32'h0000_0000;
         revs_r <= 32'h0000_0000;
      end else begin
         rpm_r <= 32'((64'(freq_r) * 64'(hsc_pkg::SEC_PER_MIN))
                      / 64'(ppr_nz)); // [RULE_18]
         revs_r <= value[0] / ppr_nz; // [RULE_19]
      end
   end

   // APB read mux, single wait-free access, unmapped reads zero with error
   logic [31:0] rdata;
   logic        hit;
   always_comb begin
      rdata = 32'h0000_0000;
      hit = 1'b1;
      if (hit_bank(paddr, hsc_pkg::OFF_LIMIT0))
         rdata = limit_r[paddr[3:2]];
      else if (hit_bank(paddr, hsc_pkg::OFF_VALUE0))
         rdata = value_cp_r[paddr[3:2]];
      else if (hit_bank(paddr, hsc_pkg::OFF_STATUS0)) begin
         rdata[hsc_pkg::ST_DIR_BIT] = dir_r[paddr[3:2]];
         // Stale linear flags stay hidden while the counter rings
         rdata[hsc_pkg::ST_OVF_BIT] = ovf[paddr[3:2]]
                                      && !ring_v[paddr[3:2]]; // [RULE_03]
         rdata[hsc_pkg::ST_UNF_BIT] = unf[paddr[3:2]]
                                      && !ring_v[paddr[3:2]]; // [RULE_03]
         rdata[hsc_pkg::ST_CMP_BIT] = cmp_run[paddr[3:2]];
      end else if (hit_bank(paddr, hsc_pkg::OFF_LATCH0))
         rdata = latch_r[paddr[3:2]];
      else if (hit_bank(paddr, hsc_pkg::OFF_CMPMAX0))
         rdata = cmpmax_r[paddr[3:2]];
      else begin
         case (paddr)
            hsc_pkg::OFF_CTRL:  rdata = ctrl_r;
            hsc_pkg::OFF_MODE:  rdata = mode_r;
            hsc_pkg::OFF_PPR:   rdata = ppr_r;
            hsc_pkg::OFF_CMD:   rdata = 32'h0000_0000;
            hsc_pkg::OFF_WDATA: rdata = wdata_r;
            hsc_pkg::OFF_FREQ:  rdata = freq_r;
            hsc_pkg::OFF_RPM:   rdata = rpm_r;
            hsc_pkg::OFF_REVS:  rdata = revs_r;
            default:            hit = 1'b0;
         endcase
      end
   end

   // Read data loads at setup, so it is settled in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !hit;
         if (rd || (psel && !penable && !pwrite)) prdata <= rdata;
      end
   end
endmodule // hsc_top
`default_nettype wire

// >>> verif/hsc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module hsc_checker #(
   parameter int SCAN_CYCLES = 16,
   parameter int GATE_CYCLES = 64
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [3:0]  pulse_up,
   input wire logic [3:0]  pulse_down,
   input wire logic [3:0]  index_in,
   input wire logic        irq_in,
   input wire logic [3:0]  cmp_run
);
   // Shadow of the mode word, so flag checks know which counters ring
   logic [31:0] mode_r;
   logic        acc;
   assign acc = psel && penable && pready;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         mode_r <= 32'h0;
      else if (acc && pwrite && paddr == hsc_pkg::OFF_MODE)
         mode_r <= pwdata;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   apb_ready_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_once_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   ready_cause_a: assert property (pready |-> $past(psel && !penable))
      else $error("ready without setup");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   err_rdata_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returns data");
   ring_flags_a: assert property (
      pready && !pwrite && paddr[7:4] == 4'h4 && mode_r[{paddr[3:2], 2'b00}]
      |-> prdata[1:0] == 2'b00) else $error("ring counter flagged limit");
   freq_cap_a: assert property (
      pready && !pwrite && paddr == hsc_pkg::OFF_FREQ |-> prdata <=
      (mode_r[3] ? hsc_pkg::FREQ_QUAD : hsc_pkg::FREQ_OTHER))
      else $error("frequency above ceiling");
   cmp_start_a: assert property (
      (cmp_run & ~$past(cmp_run)) != 4'h0 |->
      $past(acc && pwrite && paddr == hsc_pkg::OFF_CMD, 1) ||
      $past(acc && pwrite && paddr == hsc_pkg::OFF_CMD, 2))
      else $error("compare started without command");
endmodule // hsc_checker
bind hsc_top hsc_checker #(.SCAN_CYCLES(SCAN_CYCLES),
   .GATE_CYCLES(GATE_CYCLES)) chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pulse_up(pulse_up), .pulse_down(pulse_down), .index_in(index_in),
   .irq_in(irq_in), .cmp_run(cmp_run));
`default_nettype wire

// >>> verif/hsc_enc_model.sv
`timescale 1ns/1ps
`default_nettype none
module hsc_enc_model (
   input  wire logic  pclk,
   output logic [3:0] pulse_up,
   output logic [3:0] pulse_down,
   output logic [3:0] index_in,
   output logic       irq_in
);
   initial begin
      pulse_up = 4'h0;
      pulse_down = 4'h0;
      index_in = 4'h0;
      irq_in = 1'b0;
   end
   // Two cycles high, three low between pulses, so the two-flop sync sees every edge
   task automatic pulses(input int c, input logic up, input int n);
      repeat (n) begin
         @(posedge pclk);
         if (up)
            pulse_up[c] <= 1'b1;
         else
            pulse_down[c] <= 1'b1;
         repeat (2) @(posedge pclk);
         pulse_up[c] <= 1'b0;
         pulse_down[c] <= 1'b0;
         repeat (2) @(posedge pclk);
      end
   endtask
   task automatic index(input int c);
      @(posedge pclk);
      index_in[c] <= 1'b1;
      repeat (3) @(posedge pclk);
      index_in[c] <= 1'b0;
   endtask
   task automatic irq();
      @(posedge pclk);
      irq_in <= 1'b1;
      repeat (3) @(posedge pclk);
      irq_in <= 1'b0;
   endtask
endmodule // hsc_enc_model
`default_nettype wire

// >>> verif/pulse_counter_ring_reset_gate_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_counter_ring_reset_gate_tb;
   localparam logic [7:0] VAL = hsc_pkg::OFF_VALUE0;
   localparam logic [7:0] ST  = hsc_pkg::OFF_STATUS0;
   localparam logic [7:0] LIM = hsc_pkg::OFF_LIMIT0;
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, irq_in, er;
   logic [3:0]  pulse_up, pulse_down, index_in, cmp_run;
   int          n_fail = 0;
   int          num_checks = 0;
   always #4 pclk = ~pclk;
   hsc_top #(.SCAN_CYCLES(16), .GATE_CYCLES(64)) uut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pulse_up(pulse_up), .pulse_down(pulse_down),
      .index_in(index_in), .irq_in(irq_in), .cmp_run(cmp_run));
   hsc_enc_model enc (.pclk(pclk), .pulse_up(pulse_up),
      .pulse_down(pulse_down), .index_in(index_in), .irq_in(irq_in));
   task automatic close_out();
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic cmp32(input string nm, input logic [31:0] e, a);
      num_checks++;
      if (a !== e) begin
         n_fail++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, a);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         n_fail++;
         close_out();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      cmp32(nm, e, rd);
   endtask
   task automatic cmd(input logic [1:0] c, input logic [3:0] op,
                      input logic [31:0] v);
      wr(hsc_pkg::OFF_WDATA, v);
      wr(hsc_pkg::OFF_CMD, {26'h0, c, op});
   endtask
   // Longer than two scan periods, so the readout has refreshed
   task automatic settle();
      repeat (40) @(posedge pclk);
   endtask
   task automatic t_regs();
      apb(1'b0, 8'hFC, 32'h0);
      cmp32("unmapped err", 32'h1, {31'h0, er});
      wr(LIM, 32'h1234);
      rdc("limit ro", LIM, hsc_pkg::LIMIT_RST);
   endtask
   task automatic t_ring();
      wr(hsc_pkg::OFF_MODE, 32'h1);
      cmd(2'd0, hsc_pkg::CMD_SET_VALUE, 32'h3);
      cmd(2'd0, hsc_pkg::CMD_SET_LIMIT, 32'h5);
      settle();
      rdc("clear on limit", VAL, 32'h0);
      cmd(2'd0, hsc_pkg::CMD_SET_VALUE, 32'h5);
      enc.pulses(0, 1'b1, 1);
      settle();
      rdc("wrap up", VAL, 32'h0);
      enc.pulses(0, 1'b0, 1);
      settle();
      rdc("wrap down", VAL, 32'h5);
      enc.pulses(0, 1'b0, 2);
      settle();
      rdc("dir down", ST, 32'h0);
      enc.pulses(0, 1'b1, 1);
      settle();
      rdc("dir up", ST, 32'h400);
      rdc("value up", VAL, 32'h4);
   endtask
   task automatic t_zero_lim();
      cmd(2'd0, hsc_pkg::CMD_SET_LIMIT, 32'h0);
      enc.pulses(0, 1'b0, 1);
      settle();
      rdc("zero limit", VAL, hsc_pkg::ALL_ONES);
   endtask
   task automatic t_gate();
      cmd(2'd1, hsc_pkg::CMD_SET_VALUE, 32'hA);
      wr(hsc_pkg::OFF_CTRL, 32'h200);
      enc.pulses(1, 1'b1, 3);
      settle();
      rdc("gated hold", VAL + 8'h4, 32'hA);
      cmd(2'd1, hsc_pkg::CMD_SET_VALUE, 32'h14);
      settle();
      rdc("gated write", VAL + 8'h4, 32'h14);
      wr(hsc_pkg::OFF_CTRL, 32'h0);
      enc.pulses(1, 1'b1, 1);
      settle();
      rdc("ungated", VAL + 8'h4, 32'h15);
   endtask
   task automatic t_swrst();
      wr(hsc_pkg::OFF_MODE, 32'h200);
      cmd(2'd2, hsc_pkg::CMD_SET_VALUE, 32'h9);
      wr(hsc_pkg::OFF_CTRL, 32'h4);
      settle();
      rdc("sw reset", VAL + 8'h8, 32'h0);
      wr(hsc_pkg::OFF_CTRL, 32'h0);
   endtask
   task automatic t_index();
      cmd(2'd3, hsc_pkg::CMD_SET_VALUE, 32'h7);
      wr(hsc_pkg::OFF_CTRL, 32'h808);
      settle();
      rdc("armed no clear", VAL + 8'hC, 32'h7);
      enc.pulses(3, 1'b1, 2);
      settle();
      rdc("gate ignored", VAL + 8'hC, 32'h9);
      enc.index(3);
      settle();
      rdc("index clear", VAL + 8'hC, 32'h0);
      wr(hsc_pkg::OFF_CTRL, 32'h0);
   endtask
   task automatic t_cmp();
      cmd(2'd1, hsc_pkg::CMD_SET_LIMIT, 32'h64);
      wr(hsc_pkg::OFF_CMPMAX0 + 8'h4, 32'hC8);
      cmd(2'd1, hsc_pkg::CMD_CMP_START, 32'h0);
      repeat (2) @(posedge pclk);
      cmp32("cmp refused", 32'h0, {31'h0, cmp_run[1]});
      wr(hsc_pkg::OFF_CMPMAX0 + 8'h4, 32'h32);
      cmd(2'd1, hsc_pkg::CMD_CMP_START, 32'h0);
      repeat (2) @(posedge pclk);
      cmp32("cmp runs", 32'h1, {31'h0, cmp_run[1]});
      cmd(2'd1, hsc_pkg::CMD_SET_LIMIT, 32'h12C);
      rdc("limit locked", LIM + 8'h4, 32'h64);
      cmd(2'd1, hsc_pkg::CMD_CMP_STOP, 32'h0);
      repeat (2) @(posedge pclk);
      cmp32("cmp stop", 32'h0, {31'h0, cmp_run[1]});
      cmd(2'd1, hsc_pkg::CMD_CMP_START, 32'h0);
      cmd(2'd1, hsc_pkg::CMD_SW_RESET, 32'h0);
      cmp32("cmp kept", 32'h1, {31'h0, cmp_run[1]});
      wr(hsc_pkg::OFF_MODE, 32'h40);
      cmd(2'd1, hsc_pkg::CMD_SW_RESET, 32'h0);
      cmp32("cmp reset stop", 32'h0, {31'h0, cmp_run[1]});
   endtask
   task automatic t_latch();
      cmd(2'd2, hsc_pkg::CMD_SET_VALUE, 32'h55);
      settle();
      enc.irq();
      settle();
      rdc("latch", hsc_pkg::OFF_LATCH0 + 8'h8, 32'h55);
      rdc("freq idle", hsc_pkg::OFF_FREQ, 32'h0);
      wr(hsc_pkg::OFF_PPR, 32'h2);
      cmd(2'd0, hsc_pkg::CMD_SET_VALUE, 32'h7);
      rdc("revs", hsc_pkg::OFF_REVS, 32'h3);
      rdc("rpm idle", hsc_pkg::OFF_RPM, 32'h0);
      cmd(2'd1, hsc_pkg::CMD_SET_VALUE, hsc_pkg::LIN_MAX);
      enc.pulses(1, 1'b1, 1);
      settle();
      apb(1'b0, ST + 8'h4, 32'h0);
      cmp32("lin ovf", 32'h1, {30'h0, rd[1:0]});
      rdc("lin stop", VAL + 8'h4, hsc_pkg::LIN_MAX);
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_ring();
      t_zero_lim();
      t_gate();
      t_swrst();
      t_index();
      t_cmp();
      t_latch();
      close_out();
   end
   initial begin
      repeat (60000) @(posedge pclk);
      n_fail++;
      close_out();
   end
endmodule // pulse_counter_ring_reset_gate_tb
`default_nettype wire
